// ===== logic/dfs_supervisor.v
// Drive fault supervisor: detection, latching, shutdown and reporting
`timescale 1ns/100ps
`include "dfs_regs.vh"
module dfs_supervisor (
  // Clock and key-cycle reset
  input  wire       CLK_SYS,
  input  wire       RST,
  // Indicator LED driver detection, one bit per channel
  input  wire [2:0] LED_SHORT,
  input  wire [2:0] LED_OVERCURRENT,
  // Horn driver detection and configuration
  input  wire       HORN_SHORT_NEG,
  input  wire       HORN_SHORT_POS,
  input  wire       HORN_OVERCURRENT,
  input  wire       HORN_LOW_SIDE,
  // Belly-button wiring check
  input  wire       BELLY_BUTTON_WIRE_OPEN,
  // Emergency reverse and operator inputs
  input  wire       EMERGENCY_REVERSE_ACTIVE,
  input  wire       THROTTLE_ACTIVE,
  input  wire       DIRECTION_ACTIVE,
  input  wire       INTERLOCK_ACTIVE,
  input  wire       REVERSE_DIR_INTERLOCK_PARAM,
  // Emergency reverse switch pair
  input  wire       EMERGENCY_REVERSE_NO,
  input  wire       EMERGENCY_REVERSE_NC,
  // Parameter change report
  input  wire       PARAM_WRITE,
  input  wire       KEYCYCLE_REQUIRED_PARAM,
  // Motion supervision
  input  wire       MOTION_COMMANDED,
  input  wire       MOTOR_MOVING,
  // Shutdown outputs
  output reg        INDICATOR_OUT1_OFF,
  output reg        INDICATOR_OUT2_OFF,
  output reg        INDICATOR_OUT3_OFF,
  output reg        HORN_OUT_OFF,
  output reg        THROTTLE_INHIBIT,
  output reg        PARK_BRAKE_OFF,
  output reg        MAIN_RELAY_OFF,
  output reg        MOTOR_DRIVE_OFF,
  output reg        INTERLOCK_INHIBIT,
  // Fault report
  output reg        FAULT_ACTIVE,
  output reg  [3:0] FAULT_MAJOR,
  output reg  [3:0] FAULT_MINOR,
  output reg  [8:0] FAULT_VECTOR
);

  // Detection terms
  wire [2:0]             led_cause;
  wire                   horn_rail_short;
  wire                   horn_cause;
  wire                   redund_cause;
  wire                   neutral_ok;
  wire                   reverse_end;
  wire                   param_set;
  wire                   stall_set;
  wire [`DFS_NFAULT-1:0] faults;
  wire [7:0]             code;
  wire                   code_any;

  // Sequencing state
  reg                    reverse_d_reg;
  reg                    neutral_pending_reg;
  reg                    neutral_pending_next;
  reg                    neutral_fault_reg;
  reg                    neutral_fault_next;
  reg [7:0]              stall_count_reg;
  reg [7:0]              stall_count_next;

  // True when the vector holds any fault of the given shutdown set
  function in_set;
    input [`DFS_NFAULT-1:0] vec;
    input [`DFS_NFAULT-1:0] mask;
    begin
      in_set = |(vec & mask);
    end
  endfunction

  // LED channel fault cause: short or overcurrent on that channel
  assign led_cause = LED_SHORT | LED_OVERCURRENT;

  // Horn rail short depends on which side the driver switches
  assign horn_rail_short = HORN_LOW_SIDE ? HORN_SHORT_POS
                                         : HORN_SHORT_NEG;
  assign horn_cause = horn_rail_short | HORN_OVERCURRENT;

  // The switch pair must always disagree; equal levels are invalid
  assign redund_cause = ~(EMERGENCY_REVERSE_NO ^
                          EMERGENCY_REVERSE_NC);

  // Neutral: interlock counts only when the interlock option is on
  assign neutral_ok = ~THROTTLE_ACTIVE & ~DIRECTION_ACTIVE &
                      ~(INTERLOCK_ACTIVE &
                        REVERSE_DIR_INTERLOCK_PARAM);

  // End of an emergency reverse operation
  assign reverse_end = reverse_d_reg & ~EMERGENCY_REVERSE_ACTIVE;

  // Change of a parameter that only takes effect after a key cycle
  assign param_set = PARAM_WRITE & KEYCYCLE_REQUIRED_PARAM;

  // Stall once the filter count is reached
  assign stall_set = (stall_count_reg == `DFS_STALL_FILTER);

  // LED channel latches, held across a key cycle while the cause lasts
  dfs_fault_latch #(
    .CAUSE_HOLD (1'b1)
  ) u_led1 (
    .clk      (CLK_SYS),
    .rst      (RST),
    .set_in   (led_cause[0]),
    .cause_in (led_cause[0]),
    .q_reg    (faults[`DFS_F_LED1])
  );

  dfs_fault_latch #(
    .CAUSE_HOLD (1'b1)
  ) u_led2 (
    .clk      (CLK_SYS),
    .rst      (RST),
    .set_in   (led_cause[1]),
    .cause_in (led_cause[1]),
    .q_reg    (faults[`DFS_F_LED2])
  );

  dfs_fault_latch #(
    .CAUSE_HOLD (1'b1)
  ) u_led3 (
    .clk      (CLK_SYS),
    .rst      (RST),
    .set_in   (led_cause[2]),
    .cause_in (led_cause[2]),
    .q_reg    (faults[`DFS_F_LED3])
  );

  // Horn latch, held across a key cycle while the cause lasts
  dfs_fault_latch #(
    .CAUSE_HOLD (1'b1)
  ) u_horn (
    .clk      (CLK_SYS),
    .rst      (RST),
    .set_in   (horn_cause),
    .cause_in (horn_cause),
    .q_reg    (faults[`DFS_F_HORN])
  );

  // Belly-button wiring latch, cleared only if repaired at key cycle
  dfs_fault_latch #(
    .CAUSE_HOLD (1'b1)
  ) u_bb (
    .clk      (CLK_SYS),
    .rst      (RST),
    .set_in   (BELLY_BUTTON_WIRE_OPEN),
    .cause_in (BELLY_BUTTON_WIRE_OPEN),
    .q_reg    (faults[`DFS_F_BB])
  );

  // Parameter change latch, any key cycle clears it
  dfs_fault_latch #(
    .CAUSE_HOLD (1'b0)
  ) u_param (
    .clk      (CLK_SYS),
    .rst      (RST),
    .set_in   (param_set),
    .cause_in (param_set),
    .q_reg    (faults[`DFS_F_PARAM])
  );

  // Switch redundancy latch, held across a key cycle while invalid
  dfs_fault_latch #(
    .CAUSE_HOLD (1'b1)
  ) u_redund (
    .clk      (CLK_SYS),
    .rst      (RST),
    .set_in   (redund_cause),
    .cause_in (redund_cause),
    .q_reg    (faults[`DFS_F_REDUND])
  );

  // Stall latch, any key cycle clears it
  dfs_fault_latch #(
    .CAUSE_HOLD (1'b0)
  ) u_stall (
    .clk      (CLK_SYS),
    .rst      (RST),
    .set_in   (stall_set),
    .cause_in (stall_set),
    .q_reg    (faults[`DFS_F_STALL])
  );

  // Neutral-return fault is the only self-clearing slot
  assign faults[`DFS_F_NEUTRAL] = neutral_fault_reg;

  // Neutral-return check: armed at reverse end until neutral is seen
  always @* begin
    neutral_pending_next = neutral_pending_reg;
    neutral_fault_next   = neutral_fault_reg;
    if (reverse_end && !neutral_ok) begin
      neutral_pending_next = 1'b1;
    end else if (neutral_ok) begin
      neutral_pending_next = 1'b0;
    end
    if (neutral_pending_reg && THROTTLE_ACTIVE) begin
      neutral_fault_next = 1'b1;
    end else if (neutral_ok) begin
      neutral_fault_next = 1'b0;
    end
  end

  // Stall filter: counts commanded motion without movement, saturates
  always @* begin
    stall_count_next = `DFS_STALL_ZERO;
    if (MOTION_COMMANDED && !MOTOR_MOVING) begin
      if (stall_count_reg == `DFS_STALL_FILTER) begin
        stall_count_next = stall_count_reg;
      end else begin
        stall_count_next = stall_count_reg + `DFS_STALL_ONE;
      end
    end
  end

  // Sequencing registers
  always @(posedge CLK_SYS) begin
    if (RST) begin
      reverse_d_reg       <= 1'b0;
      neutral_pending_reg <= 1'b0;
      neutral_fault_reg   <= 1'b0;
      stall_count_reg     <= `DFS_STALL_ZERO;
    end else begin
      reverse_d_reg       <= EMERGENCY_REVERSE_ACTIVE;
      neutral_pending_reg <= neutral_pending_next;
      neutral_fault_reg   <= neutral_fault_next;
      stall_count_reg     <= stall_count_next;
    end
  end

  // Fault code selection
  dfs_code_encoder u_enc (
    .faults (faults),
    .code   (code),
    .any    (code_any)
  );

  // Shutdown outputs: union of the sets of all active faults
  always @(posedge CLK_SYS) begin
    if (RST) begin
      INDICATOR_OUT1_OFF <= 1'b0;
      INDICATOR_OUT2_OFF <= 1'b0;
      INDICATOR_OUT3_OFF <= 1'b0;
      HORN_OUT_OFF       <= 1'b0;
      THROTTLE_INHIBIT   <= 1'b0;
      PARK_BRAKE_OFF     <= 1'b0;
      MAIN_RELAY_OFF     <= 1'b0;
      MOTOR_DRIVE_OFF    <= 1'b0;
      INTERLOCK_INHIBIT  <= 1'b0;
    end else begin
      INDICATOR_OUT1_OFF <= in_set(faults, `DFS_SD_IND1);
      INDICATOR_OUT2_OFF <= in_set(faults, `DFS_SD_IND2);
      INDICATOR_OUT3_OFF <= in_set(faults, `DFS_SD_IND3);
      HORN_OUT_OFF       <= in_set(faults, `DFS_SD_HORN);
      THROTTLE_INHIBIT   <= in_set(faults, `DFS_SD_THROTTLE);
      PARK_BRAKE_OFF     <= in_set(faults, `DFS_SD_BRAKE);
      MAIN_RELAY_OFF     <= in_set(faults, `DFS_SD_RELAY);
      MOTOR_DRIVE_OFF    <= in_set(faults, `DFS_SD_MOTOR);
      INTERLOCK_INHIBIT  <= in_set(faults, `DFS_SD_INTERLOCK);
    end
  end

  // Fault report registers
  always @(posedge CLK_SYS) begin
    if (RST) begin
      FAULT_ACTIVE <= 1'b0;
      FAULT_MAJOR  <= 4'h0;
      FAULT_MINOR  <= 4'h0;
      FAULT_VECTOR <= 9'h000;
    end else begin
      FAULT_ACTIVE <= code_any;
      FAULT_MAJOR  <= code[7:4];
      FAULT_MINOR  <= code[3:0];
      FAULT_VECTOR <= faults;
    end
  end

endmodule // dfs_supervisor

// ===== logic/dfs_regs.vh
// Constants for the drive fault supervisor
`ifndef DFS_REGS_VH
`define DFS_REGS_VH

// Fault slots, lowest index is highest report priority
`define DFS_F_LED1     0
`define DFS_F_LED2     1
`define DFS_F_LED3     2
`define DFS_F_HORN     3
`define DFS_F_BB       4
`define DFS_F_NEUTRAL  5
`define DFS_F_PARAM    6
`define DFS_F_REDUND   7
`define DFS_F_STALL    8
`define DFS_NFAULT     9

// Fault codes, major in the high nibble and minor in the low nibble
`define DFS_CODE_LED1    8'h45
`define DFS_CODE_LED2    8'h46
`define DFS_CODE_LED3    8'h47
`define DFS_CODE_HORN    8'h48
`define DFS_CODE_BB      8'h49
`define DFS_CODE_NEUTRAL 8'h4A
`define DFS_CODE_PARAM   8'h52
`define DFS_CODE_REDUND  8'h53
`define DFS_CODE_STALL   8'h58
`define DFS_CODE_NONE    8'h00

// Shutdown sets: which faults drive each shutdown output
`define DFS_SD_IND1      9'h001
`define DFS_SD_IND2      9'h002
`define DFS_SD_IND3      9'h004
`define DFS_SD_HORN      9'h008
`define DFS_SD_THROTTLE  9'h170
`define DFS_SD_BRAKE     9'h1F0
`define DFS_SD_RELAY     9'h050
`define DFS_SD_MOTOR     9'h140
`define DFS_SD_INTERLOCK 9'h080

// Stall qualification: cycles of commanded motion without movement
`define DFS_STALL_FILTER 8'hFF
`define DFS_STALL_ZERO   8'h00
`define DFS_STALL_ONE    8'h01

`endif

// ===== logic/dfs_fault_latch.v
// Sticky fault flag with selectable behaviour across a key cycle
`timescale 1ns/100ps
module dfs_fault_latch #(
  parameter CAUSE_HOLD = 1'b0
) (
  // Clock and key-cycle reset
  input  wire clk,
  input  wire rst,
  // Detection
  input  wire set_in,
  input  wire cause_in,
  // Latched flag
  output reg  q_reg
);

  reg q_next;

  // A key cycle clears the flag, unless held open by a live cause
  always @* begin
    if (rst) begin
      q_next = cause_in & CAUSE_HOLD;
    end else begin
      q_next = q_reg | set_in;
    end
  end

  // Flag storage
  always @(posedge clk) begin
    q_reg <= q_next;
  end

endmodule // dfs_fault_latch

// ===== logic/dfs_code_encoder.v
// Priority encoder from active fault slots to a two-field code
`timescale 1ns/100ps
`include "dfs_regs.vh"
module dfs_code_encoder (
  // Active faults
  input  wire [`DFS_NFAULT-1:0] faults,
  // Reported code
  output reg  [7:0]             code,
  output reg                    any
);

  integer i;

  // Code table for one fault slot
  function [7:0] slot_code;
    input integer idx;
    begin
      case (idx)
        `DFS_F_LED1:    slot_code = `DFS_CODE_LED1;
        `DFS_F_LED2:    slot_code = `DFS_CODE_LED2;
        `DFS_F_LED3:    slot_code = `DFS_CODE_LED3;
        `DFS_F_HORN:    slot_code = `DFS_CODE_HORN;
        `DFS_F_BB:      slot_code = `DFS_CODE_BB;
        `DFS_F_NEUTRAL: slot_code = `DFS_CODE_NEUTRAL;
        `DFS_F_PARAM:   slot_code = `DFS_CODE_PARAM;
        `DFS_F_REDUND:  slot_code = `DFS_CODE_REDUND;
        `DFS_F_STALL:   slot_code = `DFS_CODE_STALL;
        default:        slot_code = `DFS_CODE_NONE;
      endcase
    end
  endfunction

  // Scan downward from the highest slot so the lowest index wins
  always @* begin
    code = `DFS_CODE_NONE;
    any  = |faults;
    for (i = `DFS_NFAULT - 1; i >= 0; i = i - 1) begin
      if (faults[i]) begin
        code = slot_code(i);
      end
    end
  end

endmodule // dfs_code_encoder

// ===== tb/dfs_supervisor_sva.sv
// Concurrent checks on the fault supervisor ports
`timescale 1ns/100ps
module dfs_supervisor_chk (
  // Clock and reset
  input wire       CLK_SYS,
  input wire       RST,
  // Causes
  input wire [2:0] LED_SHORT,
  input wire [2:0] LED_OVERCURRENT,
  input wire       BELLY_BUTTON_WIRE_OPEN,
  input wire       THROTTLE_ACTIVE,
  input wire       DIRECTION_ACTIVE,
  input wire       INTERLOCK_ACTIVE,
  input wire       REVERSE_DIR_INTERLOCK_PARAM,
  input wire       EMERGENCY_REVERSE_NO,
  input wire       EMERGENCY_REVERSE_NC,
  input wire       PARAM_WRITE,
  input wire       KEYCYCLE_REQUIRED_PARAM,
  // Results
  input wire       INDICATOR_OUT1_OFF,
  input wire       THROTTLE_INHIBIT,
  input wire       PARK_BRAKE_OFF,
  input wire       MAIN_RELAY_OFF,
  input wire       MOTOR_DRIVE_OFF,
  input wire       INTERLOCK_INHIBIT,
  input wire       FAULT_ACTIVE,
  input wire [3:0] FAULT_MAJOR,
  input wire [3:0] FAULT_MINOR,
  input wire [8:0] FAULT_VECTOR
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  // Cause to shutdown takes two edges
  a_led1_off: assert property (
    LED_SHORT[0] | LED_OVERCURRENT[0] |-> ##2 INDICATOR_OUT1_OFF)
    else $error("led1 not shut");
  a_bb_shut: assert property (
    BELLY_BUTTON_WIRE_OPEN |->
    ##2 THROTTLE_INHIBIT && PARK_BRAKE_OFF && MAIN_RELAY_OFF)
    else $error("wire fault shutdown");
  a_param_shut: assert property (
    PARAM_WRITE && KEYCYCLE_REQUIRED_PARAM |->
    ##2 MOTOR_DRIVE_OFF && MAIN_RELAY_OFF && PARK_BRAKE_OFF &&
    THROTTLE_INHIBIT)
    else $error("param shutdown");
  a_switch_pair: assert property (
    EMERGENCY_REVERSE_NO == EMERGENCY_REVERSE_NC |->
    ##2 INTERLOCK_INHIBIT && PARK_BRAKE_OFF)
    else $error("pair fault");
  // Each of the param and stall bits, once set, stays set
  a_sticky_hold: assert property (
    (FAULT_VECTOR[6] || FAULT_VECTOR[8]) |=>
    ((FAULT_VECTOR[8:6] & $past(FAULT_VECTOR[8:6]) & 3'h5) ==
     ($past(FAULT_VECTOR[8:6]) & 3'h5)))
    else $error("sticky fault lost");
  a_shut_or: assert property (
    THROTTLE_INHIBIT == |(FAULT_VECTOR & 9'h170) &&
    PARK_BRAKE_OFF == |(FAULT_VECTOR & 9'h1F0) &&
    MAIN_RELAY_OFF == |(FAULT_VECTOR & 9'h050) &&
    MOTOR_DRIVE_OFF == |(FAULT_VECTOR & 9'h140))
    else $error("shutdown set mismatch");
  a_code_first: assert property (
    FAULT_VECTOR[0] |-> {FAULT_MAJOR, FAULT_MINOR} == 8'h45)
    else $error("priority code");
  a_active_flag: assert property (
    FAULT_ACTIVE == (FAULT_VECTOR != 9'h000) &&
    (FAULT_ACTIVE || {FAULT_MAJOR, FAULT_MINOR} == 8'h00))
    else $error("active flag");
  a_neutral_clear: assert property (
    FAULT_VECTOR[5] && !THROTTLE_ACTIVE && !DIRECTION_ACTIVE &&
    !(INTERLOCK_ACTIVE && REVERSE_DIR_INTERLOCK_PARAM) |->
    ##2 !FAULT_VECTOR[5])
    else $error("neutral not cleared");

  // Main scenarios reached
  c_neutral: cover property (FAULT_VECTOR[5]);
  c_stall: cover property (FAULT_VECTOR[8] && FAULT_VECTOR[6]);
  c_pair: cover property (FAULT_VECTOR[7] && FAULT_VECTOR[4]);
endmodule // dfs_supervisor_chk

bind dfs_supervisor dfs_supervisor_chk dfs_supervisor_chk_i (.*);

// ===== tb/dfs_drive_stage.sv
// Model of the indicator driver stages and reverse switch pair
`timescale 1ns/100ps
module dfs_drive_stage (
  // Clock
  input  wire       clk,
  // Stimulus from the bench
  input  wire [2:0] short_inj,
  input  wire [2:0] chan_off,
  input  wire       rev_sw,
  input  wire       stuck,
  // Sensed levels towards the supervisor
  output reg  [2:0] led_short = 3'h0,
  output reg        sw_no = 1'b0,
  output reg        sw_nc = 1'b1
);
  // A short shows only while the stage drives; stuck contact breaks pair
  always @(posedge clk) begin
    led_short <= short_inj & ~chan_off;
    sw_no     <= rev_sw | stuck;
    sw_nc     <= ~rev_sw | stuck;
  end
endmodule // dfs_drive_stage

// ===== tb/testbench.sv
// Self-checking bench for the drive fault supervisor
`timescale 1ns/100ps
module testbench;
  // Design inputs
  reg        CLK_SYS = 1'b0;
  reg        RST = 1'b1;
  reg  [2:0] LED_OVERCURRENT = 3'h0;
  reg        HORN_SHORT_NEG = 1'b0, HORN_SHORT_POS = 1'b0;
  reg        HORN_OVERCURRENT = 1'b0, HORN_LOW_SIDE = 1'b0;
  reg        BELLY_BUTTON_WIRE_OPEN = 1'b0, EMERGENCY_REVERSE_ACTIVE = 1'b0;
  reg        THROTTLE_ACTIVE = 1'b0, DIRECTION_ACTIVE = 1'b0;
  reg        INTERLOCK_ACTIVE = 1'b0, REVERSE_DIR_INTERLOCK_PARAM = 1'b0;
  reg        PARAM_WRITE = 1'b0, KEYCYCLE_REQUIRED_PARAM = 1'b0;
  reg        MOTION_COMMANDED = 1'b0, MOTOR_MOVING = 1'b0;
  // Partner stimulus
  reg  [2:0] inj = 3'h0;
  reg        rev_sw = 1'b0, stuck = 1'b0;
  // Partner model outputs and design outputs
  wire [2:0] LED_SHORT;
  wire       EMERGENCY_REVERSE_NO, EMERGENCY_REVERSE_NC;
  wire       INDICATOR_OUT1_OFF, INDICATOR_OUT2_OFF, INDICATOR_OUT3_OFF;
  wire       HORN_OUT_OFF, THROTTLE_INHIBIT, PARK_BRAKE_OFF, MAIN_RELAY_OFF;
  wire       MOTOR_DRIVE_OFF, INTERLOCK_INHIBIT, FAULT_ACTIVE;
  wire [3:0] FAULT_MAJOR, FAULT_MINOR;
  wire [8:0] FAULT_VECTOR;
  // Shutdown bundle and code for comparison
  wire [8:0] sd = {INDICATOR_OUT1_OFF, INDICATOR_OUT2_OFF, INDICATOR_OUT3_OFF,
    HORN_OUT_OFF, THROTTLE_INHIBIT, PARK_BRAKE_OFF, MAIN_RELAY_OFF,
    MOTOR_DRIVE_OFF, INTERLOCK_INHIBIT};
  wire [8:0] code = {1'b0, FAULT_MAJOR, FAULT_MINOR};
  integer    err_total = 0, n_checks = 0;

  dfs_supervisor dfs_supervisor_i (.*);
  dfs_drive_stage dfs_drive_stage_i (.clk(CLK_SYS), .short_inj(inj),
    .chan_off({INDICATOR_OUT3_OFF, INDICATOR_OUT2_OFF, INDICATOR_OUT1_OFF}),
    .rev_sw(rev_sw), .stuck(stuck), .led_short(LED_SHORT),
    .sw_no(EMERGENCY_REVERSE_NO), .sw_nc(EMERGENCY_REVERSE_NC));

  // 100 ns clock
  always #50 CLK_SYS = ~CLK_SYS;

  // Compare and count
  task chk(input string what, input [8:0] exp, input [8:0] got);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  task cyc(input integer n);
    repeat (n) @(posedge CLK_SYS);
  endtask

  // Key cycle: reset for ten cycles, then settle
  task key_cycle;
    begin
      @(posedge CLK_SYS);
      RST <= 1'b1;
      cyc(10);
      RST <= 1'b0;
      cyc(4);
    end
  endtask

  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
        $display("TB: PASS");
      end else begin
        $display("TB: FAIL");
      end
      $finish;
    end
  endtask

  // Indicator faults stay through a key cycle while the short remains
  task t_led;
    begin
      @(posedge CLK_SYS);
      inj <= 3'h5;
      LED_OVERCURRENT <= 3'h2;
      cyc(4);
      chk("vector", 9'h007, FAULT_VECTOR);
      chk("shutdown", 9'h1C0, sd);
      chk("code", 9'h045, code);
      chk("active", 9'h001, {8'h00, FAULT_ACTIVE});
      LED_OVERCURRENT <= 3'h0;
      key_cycle;
      chk("vector", 9'h005, FAULT_VECTOR);
      inj <= 3'h0;
      key_cycle;
      chk("vector", 9'h000, FAULT_VECTOR);
    end
  endtask

  // Horn cases: {low side, neg, pos, overcurrent, expected}
  task t_horn;
    reg [24:0] tab;
    reg [4:0]  c;
    integer    i;
    begin
      tab = {5'h09, 5'h15, 5'h04, 5'h18, 5'h03};
      for (i = 0; i < 5; i = i + 1) begin
        c = tab[i*5 +: 5];
        @(posedge CLK_SYS);
        {HORN_LOW_SIDE, HORN_SHORT_NEG, HORN_SHORT_POS,
         HORN_OVERCURRENT} <= c[4:1];
        cyc(4);
        chk("horn", {8'h00, c[0]}, {8'h00, HORN_OUT_OFF});
        {HORN_SHORT_NEG, HORN_SHORT_POS, HORN_OVERCURRENT} <= 3'h0;
        key_cycle;
      end
    end
  endtask

  // Wiring fault, then a stuck reverse contact on top of it
  task t_bb_pair;
    begin
      @(posedge CLK_SYS);
      BELLY_BUTTON_WIRE_OPEN <= 1'b1;
      cyc(4);
      chk("shutdown", 9'h01C, sd);
      BELLY_BUTTON_WIRE_OPEN <= 1'b0;
      stuck <= 1'b1;
      cyc(4);
      chk("shutdown", 9'h01D, sd);
      chk("vector", 9'h090, FAULT_VECTOR);
      chk("code", 9'h049, code);
      key_cycle;
      chk("vector", 9'h080, FAULT_VECTOR);
      stuck <= 1'b0;
      key_cycle;
      chk("vector", 9'h000, FAULT_VECTOR);
    end
  endtask

  // Parameter change, then stall filter restart and latch
  task t_param_stall;
    begin
      @(posedge CLK_SYS);
      PARAM_WRITE <= 1'b1;
      cyc(1);
      PARAM_WRITE <= 1'b0;
      cyc(4);
      chk("vector", 9'h000, FAULT_VECTOR);
      KEYCYCLE_REQUIRED_PARAM <= 1'b1;
      PARAM_WRITE <= 1'b1;
      cyc(1);
      PARAM_WRITE <= 1'b0;
      KEYCYCLE_REQUIRED_PARAM <= 1'b0;
      MOTION_COMMANDED <= 1'b1;
      cyc(240);
      chk("shutdown", 9'h01E, sd);
      MOTOR_MOVING <= 1'b1;
      cyc(1);
      MOTOR_MOVING <= 1'b0;
      cyc(250);
      chk("vector", 9'h040, FAULT_VECTOR);
      cyc(20);
      chk("vector", 9'h140, FAULT_VECTOR);
      MOTION_COMMANDED <= 1'b0;
      cyc(4);
      chk("vector", 9'h140, FAULT_VECTOR);
      key_cycle;
      chk("vector", 9'h000, FAULT_VECTOR);
    end
  endtask

  // Drive attempt after reverse, cleared by neutral, interlock off and on
  task t_neutral;
    integer p;
    begin
      for (p = 0; p < 2; p = p + 1) begin
        @(posedge CLK_SYS);
        REVERSE_DIR_INTERLOCK_PARAM <= p[0];
        EMERGENCY_REVERSE_ACTIVE <= 1'b1;
        rev_sw <= 1'b1;
        {THROTTLE_ACTIVE, DIRECTION_ACTIVE, INTERLOCK_ACTIVE} <= 3'h7;
        cyc(2);
        EMERGENCY_REVERSE_ACTIVE <= 1'b0;
        rev_sw <= 1'b0;
        cyc(5);
        chk("shutdown", 9'h018, sd);
        chk("code", 9'h04A, code);
        {THROTTLE_ACTIVE, DIRECTION_ACTIVE} <= 2'h0;
        cyc(4);
        chk("neutral", {8'h00, p[0]}, {8'h00, FAULT_VECTOR[5]});
        INTERLOCK_ACTIVE <= 1'b0;
        cyc(4);
        chk("vector", 9'h000, FAULT_VECTOR);
      end
    end
  endtask

  // Hang guard
  initial begin
    cyc(5000);
    err_total = err_total + 1;
    wrap_up;
  end

  // Main sequence
  initial begin
    cyc(10);
    RST <= 1'b0;
    cyc(2);
    t_led;
    t_horn;
    t_bb_pair;
    t_param_stall;
    t_neutral;
    wrap_up;
  end
endmodule // testbench
